// File: include/pme_pkg.sv
package pme_pkg;
	// Register offsets from the block base
	localparam logic [3:0] OFS_STATUS_LOW  = 4'h0;
	localparam logic [3:0] OFS_STATUS_HIGH = 4'h1;
	localparam logic [3:0] OFS_ENABLE_LOW  = 4'h2;
	localparam logic [3:0] OFS_ENABLE_HIGH = 4'h3;
	localparam logic [3:0] OFS_CONTROL_LOW = 4'h4;
	localparam logic [3:0] OFS_CONTROL_HIGH = 4'h5;
	// Bit positions
	localparam int BIT_TICK     = 0;
	localparam int BIT_FIRMWARE = 5;
	localparam int BIT_BUTTON   = 0;
	localparam int BIT_ALARM    = 2;
	localparam int BIT_OVERRIDE = 3;
	localparam int BIT_WAKE     = 7;
	localparam int BIT_SCI_GATE = 0;
	localparam int BIT_RELEASE  = 2;
	localparam int BIT_OR_EN    = 1;
	localparam int BIT_COUNTER_MSB = 23;
	// Writable masks (reserved bits read zero)
	localparam logic [7:0] MASK_STATUS_LOW  = 8'h21;
	localparam logic [7:0] MASK_STATUS_HIGH = 8'h8D;
	localparam logic [7:0] MASK_ENABLE_LOW  = 8'h21;
	localparam logic [7:0] MASK_ENABLE_HIGH = 8'h05;
	localparam logic [7:0] MASK_CONTROL_LOW = 8'h05;
	localparam logic [7:0] MASK_CONTROL_HIGH = 8'h02;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Override hold time
	localparam longint CLK_HZ        = 100000000;
	localparam longint HOLD_SECONDS  = 4;
	localparam longint HOLD_CYCLES   = CLK_HZ * HOLD_SECONDS;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} pme_bus_req_type;
	typedef enum logic [1:0] {
		PME_OFF,
		PME_ON
	} pme_power_type;
endpackage : pme_pkg

// File: rtl/pme_event_logic.sv
`timescale 1ns/1ps
// What this block does
// - Alarm pulse sets alarm flag, status-high bit 2
// - Enabled alarm flag raises SCI
// - Override enabled, button held over 4 s while on sets flag
// - Override also clears button press flag
// - Wake flag sets on supply-request falling edge
// - Wake flag clears by write-one only while on
// - Wake request moves power state to on
// - Flags hardware-set, write-one-clear, reset cleared
// - Reserved bits always read zero
// - Tick rollover enable gates tick flag SCI
// - Firmware release enable and flag raise SCI
// - Button press enable gates SCI or wake
// - Button press flag sets regardless of enable
// - Enable/control bytes RW in writable-mask bits only, reset 00h
// - Tick flag sets on counter bit 23 toggle
// - Firmware release request sets firmware flag
// - SCI gate bit masks all SCI
// - Button assertion sets button press flag
module pme_event_logic #(
	parameter longint HOLD_CYCLES = pme_pkg::HOLD_CYCLES
) (
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_in,
	input  wire pme_pkg::pme_bus_req_type bus_in,
	output logic [7:0]                    rdata_out,
	input  wire logic                     button_in,
	input  wire logic                     alarm_in,
	input  wire logic                     counter_msb_in,
	input  wire logic                     resume_event_in,
	output logic                          main_supply_request_n_out,
	output logic                          sci_out,
	output logic                          wake_request_out
);
	logic [1:0] button_sync;
	logic [1:0] alarm_sync;
	logic [1:0] msb_sync;
	logic [1:0] resume_sync;
	logic       button_prev;
	logic       alarm_prev;
	logic       msb_prev;
	logic       supply_prev_n;
	logic [7:0] status_low;
	logic [7:0] status_high;
	logic [7:0] event_enable_low;
	logic [7:0] event_enable_high;
	logic [7:0] power_control_low;
	logic [7:0] power_control_high;
	logic [31:0] hold_count;
	logic       override_fire;
	logic       held_done;
	logic       wr_status_low;
	logic       wr_status_high;
	logic       wake_clear_ok;
	pme_pkg::pme_power_type power_state;

	// Two-flop synchronisers for outside inputs
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			button_sync <= 2'h0;
			alarm_sync  <= 2'h0;
			msb_sync    <= 2'h0;
			resume_sync <= 2'h0;
		end else begin
			button_sync <= {button_sync[0], button_in};
			alarm_sync  <= {alarm_sync[0], alarm_in};
			msb_sync    <= {msb_sync[0], counter_msb_in};
			resume_sync <= {resume_sync[0], resume_event_in};
		end
	end

	// Edge history
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			button_prev   <= 1'b0;
			alarm_prev    <= 1'b0;
			msb_prev      <= 1'b0;
			supply_prev_n <= 1'b0;
		end else begin
			button_prev   <= button_sync[1];
			alarm_prev    <= alarm_sync[1];
			msb_prev      <= msb_sync[1];
			supply_prev_n <= main_supply_request_n_out;
		end
	end

	// Button hold timer
	assign held_done = (64'(hold_count) >= HOLD_CYCLES);
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !button_sync[1]) begin
			hold_count <= 32'h0;
		end else if (!held_done) begin
			hold_count <= hold_count + 32'h1;
		end
	end
	assign override_fire = button_sync[1] && held_done && !status_high[pme_pkg::BIT_OVERRIDE]
		&& power_control_high[pme_pkg::BIT_OR_EN] && power_state == pme_pkg::PME_ON;

	assign wr_status_low  = bus_in.wr && bus_in.addr == pme_pkg::OFS_STATUS_LOW;
	assign wr_status_high = bus_in.wr && bus_in.addr == pme_pkg::OFS_STATUS_HIGH;
	assign wake_clear_ok  = !main_supply_request_n_out;

	// Status byte low: tick and firmware release flags, set wins over clear for tick only
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			status_low <= pme_pkg::RESET_BYTE;
		end else begin
			if (wr_status_low) begin
				status_low <= status_low & ~(bus_in.wdata & pme_pkg::MASK_STATUS_LOW);
			end
			if (msb_sync[1] != msb_prev) begin
				status_low[pme_pkg::BIT_TICK] <= 1'b1;
			end
			// Clearing write also drops the request, so no re-set
			if (power_control_low[pme_pkg::BIT_RELEASE]
				&& !(wr_status_low && bus_in.wdata[pme_pkg::BIT_FIRMWARE])) begin
				status_low[pme_pkg::BIT_FIRMWARE] <= 1'b1;
			end
		end
	end

	// Status byte high: button, alarm, override, wake
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			status_high <= pme_pkg::RESET_BYTE;
		end else begin
			if (wr_status_high) begin
				status_high <= status_high & ~(bus_in.wdata & pme_pkg::MASK_STATUS_HIGH
					& {wake_clear_ok, 7'h7F});
			end
			if (button_sync[1] && !button_prev) begin
				status_high[pme_pkg::BIT_BUTTON] <= 1'b1;
			end
			if (alarm_sync[1] && !alarm_prev) begin
				status_high[pme_pkg::BIT_ALARM] <= 1'b1;
			end
			if (override_fire) begin
				status_high[pme_pkg::BIT_OVERRIDE] <= 1'b1;
				status_high[pme_pkg::BIT_BUTTON]   <= 1'b0;
			end
			if (supply_prev_n && !main_supply_request_n_out) begin
				status_high[pme_pkg::BIT_WAKE] <= 1'b1;
			end
		end
	end

	// Enable and control bytes
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			event_enable_low   <= pme_pkg::RESET_BYTE;
			event_enable_high  <= pme_pkg::RESET_BYTE;
			power_control_low  <= pme_pkg::RESET_BYTE;
			power_control_high <= pme_pkg::RESET_BYTE;
		end else begin
			if (bus_in.wr && bus_in.addr == pme_pkg::OFS_ENABLE_LOW) begin
				event_enable_low <= bus_in.wdata & pme_pkg::MASK_ENABLE_LOW;
			end
			if (bus_in.wr && bus_in.addr == pme_pkg::OFS_ENABLE_HIGH) begin
				event_enable_high <= bus_in.wdata & pme_pkg::MASK_ENABLE_HIGH;
			end
			if (bus_in.wr && bus_in.addr == pme_pkg::OFS_CONTROL_LOW) begin
				power_control_low <= bus_in.wdata & pme_pkg::MASK_CONTROL_LOW;
			end else if (wr_status_low && bus_in.wdata[pme_pkg::BIT_FIRMWARE]) begin
				power_control_low[pme_pkg::BIT_RELEASE] <= 1'b0;
			end
			if (bus_in.wr && bus_in.addr == pme_pkg::OFS_CONTROL_HIGH) begin
				power_control_high <= bus_in.wdata & pme_pkg::MASK_CONTROL_HIGH;
			end
		end
	end

	// Power state: wake request to on, override to off
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			power_state <= pme_pkg::PME_ON;
		end else begin
			case (power_state)
				pme_pkg::PME_ON: begin
					if (override_fire) begin
						power_state <= pme_pkg::PME_OFF;
					end
				end
				pme_pkg::PME_OFF: begin
					if (wake_request_out) begin
						power_state <= pme_pkg::PME_ON;
					end
				end
				default: begin
					power_state <= pme_pkg::PME_ON;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			main_supply_request_n_out <= 1'b0;
		end else begin
			// Follows the next power state, so supply and state never disagree
			if (power_state == pme_pkg::PME_ON) begin
				main_supply_request_n_out <= override_fire;
			end else begin
				main_supply_request_n_out <= !wake_request_out;
			end
		end
	end

	// Resume while off: synced resume or enabled button press
	assign wake_request_out = power_state == pme_pkg::PME_OFF && (resume_sync[1]
		|| (status_high[pme_pkg::BIT_BUTTON] && event_enable_high[pme_pkg::BIT_BUTTON]));

	// SCI level
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sci_out <= 1'b0;
		end else begin
			sci_out <= power_control_low[pme_pkg::BIT_SCI_GATE] && (
				(status_low[pme_pkg::BIT_TICK] && event_enable_low[pme_pkg::BIT_TICK])
				|| (status_low[pme_pkg::BIT_FIRMWARE]
					&& event_enable_low[pme_pkg::BIT_FIRMWARE])
				|| (status_high[pme_pkg::BIT_ALARM]
					&& event_enable_high[pme_pkg::BIT_ALARM])
				|| (power_state == pme_pkg::PME_ON && status_high[pme_pkg::BIT_BUTTON]
					&& event_enable_high[pme_pkg::BIT_BUTTON]));
		end
	end

	// Read data
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (bus_in.rd) begin
			case (bus_in.addr)
				pme_pkg::OFS_STATUS_LOW:   rdata_out <= status_low & pme_pkg::MASK_STATUS_LOW;
				pme_pkg::OFS_STATUS_HIGH:  rdata_out <= status_high & pme_pkg::MASK_STATUS_HIGH;
				pme_pkg::OFS_ENABLE_LOW:   rdata_out <= event_enable_low;
				pme_pkg::OFS_ENABLE_HIGH:  rdata_out <= event_enable_high;
				pme_pkg::OFS_CONTROL_LOW:  rdata_out <= power_control_low;
				pme_pkg::OFS_CONTROL_HIGH: rdata_out <= power_control_high;
				default:                   rdata_out <= 8'h00;
			endcase
		end
	end
endmodule : pme_event_logic

// File: tb/pme_event_props.sv
`timescale 1ns/1ps
module pme_event_props #(
	parameter longint HOLD_CYCLES = 20
) (
	input wire logic                     sys_clk_in,
	input wire logic                     rst_in,
	input wire pme_pkg::pme_bus_req_type bus_in,
	input wire logic [7:0]               rdata_out,
	input wire logic                     button_in,
	input wire logic                     alarm_in,
	input wire logic                     counter_msb_in,
	input wire logic                     resume_event_in,
	input wire logic                     main_supply_request_n_out,
	input wire logic                     sci_out,
	input wire logic                     wake_request_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	sequence rd_at(a);
		bus_in.rd && bus_in.addr == a;
	endsequence
	sequence resume_held;
		main_supply_request_n_out && resume_event_in ##1 resume_event_in [*2];
	endsequence
	reset_state_a: assert property (disable iff (1'b0) rst_in |=> rdata_out == 8'h00
		&& !sci_out && !main_supply_request_n_out) else $error("reset state wrong");
	status_rsvd_a: assert property (rd_at(4'h1) |=> rdata_out[6:4] == 3'h0)
		else $error("status reserved bits set");
	enable_rsvd_a: assert property (rd_at(4'h2) |=> rdata_out[4:1] == 4'h0)
		else $error("enable reserved bits set");
	unmapped_read_a: assert property (bus_in.rd && bus_in.addr > 4'h5 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	enable_rw_a: assert property (bus_in.wr && bus_in.addr == 4'h2 ##2 rd_at(4'h2)
		|=> rdata_out == ($past(bus_in.wdata, 3) & 8'h21)) else $error("enable readback wrong");
	gate_off_a: assert property (bus_in.wr && bus_in.addr == 4'h4 && !bus_in.wdata[0]
		|-> ##[1:3] !sci_out) else $error("sci not gated");
	wake_off_a: assert property (!main_supply_request_n_out |-> !wake_request_out)
		else $error("wake request while on");
	resume_on_a: assert property (resume_held |-> ##[0:6] !main_supply_request_n_out)
		else $error("resume did not power on");
endmodule : pme_event_props
bind pme_event_logic pme_event_props #(.HOLD_CYCLES(HOLD_CYCLES)) pme_event_props_i (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
	.button_in(button_in), .alarm_in(alarm_in), .counter_msb_in(counter_msb_in),
	.resume_event_in(resume_event_in), .main_supply_request_n_out(main_supply_request_n_out),
	.sci_out(sci_out), .wake_request_out(wake_request_out));

// File: tb/pme_host_model.sv
`timescale 1ns/1ps
module pme_host_model (
	input  wire logic                 sys_clk_in,
	input  wire logic [7:0]           rdata_in,
	output pme_pkg::pme_bus_req_type  bus_out
);
	initial bus_out = '0;
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		bus_out <= '{1'b0, 1'b1, a, d};
		@(posedge sys_clk_in);
		bus_out <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		bus_out <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk_in);
		bus_out <= '0;
		#1 d = rdata_in;
	endtask : rd
endmodule : pme_host_model

// File: tb/pme_event_logic_tb.sv
`timescale 1ns/1ps
module pme_event_logic_tb;
	logic                     sys_clk_in, rst_in, button, alarm, msb, resume, main_n, sci, wreq;
	pme_pkg::pme_bus_req_type bus;
	logic [7:0]               rdata, got;
	int                       num_errors = 0;
	int                       compares = 0;
	logic [19:0]              rows [7] = '{20'h2FF21, 20'h3FF05, 20'h4FA00, 20'h5FD00,
		20'h6FF00, 20'h30000, 20'h20000};
	pme_event_logic #(.HOLD_CYCLES(20)) pme_event_logic_i (.sys_clk_in(sys_clk_in),
		.rst_in(rst_in), .bus_in(bus), .rdata_out(rdata), .button_in(button), .alarm_in(alarm),
		.counter_msb_in(msb), .resume_event_in(resume), .main_supply_request_n_out(main_n),
		.sci_out(sci), .wake_request_out(wreq));
	pme_host_model pme_host_model_i (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .bus_out(bus));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		pme_host_model_i.rd(a, got);
		chk("rdata", e, got);
	endtask : rchk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		pme_host_model_i.wr(a, d);
	endtask : wr
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : settle
	task end_sim;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		settle(4000);
		num_errors++;
		end_sim;
	end
	initial begin
		{rst_in, button, alarm, msb, resume} = 5'h10;
		settle(4);
		rst_in <= 1'b0;
		for (int i = 0; i < 6; i++)
			rchk(i[3:0], 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rchk(rows[i][19:16], rows[i][7:0]);
		end
		wr(4'h3, 8'h04);
		wr(4'h4, 8'h01);
		alarm <= 1'b1;
		settle(1);
		alarm <= 1'b0;
		settle(6);
		rchk(4'h1, 8'h04);
		chk("sci", 8'h01, {7'h00, sci});
		wr(4'h1, 8'h00);
		rchk(4'h1, 8'h04);
		wr(4'h4, 8'h00);
		settle(6);
		chk("sci", 8'h00, {7'h00, sci});
		wr(4'h4, 8'h01);
		wr(4'h1, 8'h04);
		settle(6);
		chk("sci", 8'h00, {7'h00, sci});
		msb <= 1'b1;
		settle(6);
		rchk(4'h0, 8'h01);
		chk("sci", 8'h00, {7'h00, sci});
		wr(4'h2, 8'h01);
		settle(6);
		chk("sci", 8'h01, {7'h00, sci});
		wr(4'h0, 8'h01);
		msb <= 1'b0;
		settle(6);
		rchk(4'h0, 8'h01);
		wr(4'h0, 8'h01);
		wr(4'h2, 8'h20);
		wr(4'h4, 8'h05);
		settle(6);
		rchk(4'h0, 8'h20);
		chk("sci", 8'h01, {7'h00, sci});
		wr(4'h0, 8'h20);
		rchk(4'h0, 8'h00);
		wr(4'h5, 8'h02);
		for (int i = 0; i < 4; i++) begin
			button <= ~button;
			settle(i[0] ? 3 : 15);
		end
		rchk(4'h1, 8'h01);
		chk("sci", 8'h00, {7'h00, sci});
		wr(4'h3, 8'h01);
		settle(6);
		chk("sci", 8'h01, {7'h00, sci});
		for (int i = 0; i < 2; i++) begin
			button <= 1'b1;
			settle(30);
			button <= 1'b0;
			chk("supply_n", 8'h01, {7'h00, main_n});
			chk("wake_req", 8'h00, {7'h00, wreq});
			wr(4'h1, 8'h80);
			rchk(4'h1, i ? 8'h88 : 8'h08);
			resume <= 1'b1;
			settle(12);
			resume <= 1'b0;
			chk("supply_n", 8'h00, {7'h00, main_n});
			rchk(4'h1, 8'h88);
			wr(4'h1, 8'h08);
		end
		wr(4'h1, 8'h80);
		rchk(4'h1, 8'h00);
		end_sim;
	end
endmodule : pme_event_logic_tb
